/* File: verification/tb.sv */
// Self-checking bench for the rotate, return and flag-set execution block.
// Assumes the package and block under verilog/ are compiled first.
`timescale 1ns/10ps

module tb;
    import rotate_return_flag_pkg::*;

    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, target_value, flags_word_in;
    logic [31:0] saved_flags_word, exception_return_address;
    logic [31:0] call_link_register, rn_wr_data, flags_wr_data;
    logic [31:0] slot_fetch_flags, branch_target, d, v, ev;
    issue_t      issue;
    logic [3:0]  rn_wr_idx;
    logic        issue_ready, rn_wr_en, flags_wr_en, branch_go, irq_block;
    logic        illegal_general, illegal_slot, irq, e, ec;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [15:0] rops [3] = '{OP_ROT_RCR, OP_ROT_RLC, OP_ROT_RRC};
    logic [31:0] rvals [2] = '{32'h8000_0001, 32'h7FFF_FFFE};

    rotate_return_flag_exec i_rotate_return_flag_exec (
        .clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue(issue), .target_value(target_value),
        .flags_word_in(flags_word_in), .saved_flags_word(saved_flags_word),
        .exception_return_address(exception_return_address),
        .call_link_register(call_link_register),
        .issue_ready(issue_ready), .rn_wr_en(rn_wr_en),
        .rn_wr_idx(rn_wr_idx), .rn_wr_data(rn_wr_data),
        .flags_wr_en(flags_wr_en), .flags_wr_data(flags_wr_data),
        .slot_fetch_flags(slot_fetch_flags), .branch_go(branch_go),
        .branch_target(branch_target), .irq_block(irq_block),
        .illegal_general(illegal_general), .illegal_slot(illegal_slot),
        .irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] z(input logic x);
        return {31'h0, x};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hangs are cut short here rather than in each wait loop
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            close_out();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Answer and data are taken at the edge that sees pready high
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, d, x);
    endtask

    // Offer one instruction; returns in the cycle after its acceptance
    task automatic send(input logic [15:0] op, input logic s, input logic b);
        @(posedge clk);
        issue <= {1'b1, s, b, op};
        do @(posedge clk); while (issue_ready !== 1'b1);
        issue <= '0;
        @(negedge clk);
    endtask

    task automatic irq_chk(input string nm, input logic x);
        @(posedge clk);
        @(negedge clk);
        chk(nm, z(irq), z(x));
    endtask

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        issue = '0;
        target_value = 32'h0;
        flags_word_in = 32'h4000_0000;
        saved_flags_word = 32'h0;
        exception_return_address = 32'h0;
        call_link_register = 32'h0;
        repeat (6) @(posedge clk);
        chk("rdy_rst", z(issue_ready), 32'h0);
        reset <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("rdy", z(issue_ready), 32'h1);
        rchk("ctrl", ADDR_CTRL, CTRL_RESET);
        rchk("mask", ADDR_MASK, 32'h0);
        rchk("stat", ADDR_STATUS, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unm_d", d, 32'h0);
        chk("unm_e", z(e), 32'h1);
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 2; j++) begin
                v = rvals[j];
                case (i)
                    0: begin ev = {j[0], v[31:1]}; ec = v[0]; end
                    1: begin ev = {v[30:0], v[31]}; ec = v[31]; end
                    default: begin ev = {v[0], v[31:1]}; ec = v[0]; end
                endcase
                @(posedge clk);
                target_value  <= v;
                flags_word_in <= 32'h4000_0000 | 32'(j);
                send(rops[i] | {4'h0, 4'(i * 5 + j), 8'h00}, 1'b0, 1'b0);
                chk("rn_en", z(rn_wr_en), 32'h1);
                chk("rn_idx", z(1'b0) | rn_wr_idx, i * 5 + j);
                chk("rn_d", rn_wr_data, ev);
                v = 32'h4000_0000 | ec;
                chk("fl_d", flags_wr_data, v);
            end
        end
        @(posedge clk);
        flags_word_in <= 32'h4000_0001;
        send(OP_SET_CLMP, 1'b0, 1'b0);
        chk("clmp_en", z(flags_wr_en), 32'h1);
        chk("clmp", flags_wr_data, 32'h4000_0003);
        @(posedge clk);
        flags_word_in <= 32'h4000_0002;
        send(OP_SET_CARY, 1'b0, 1'b0);
        chk("cary", flags_wr_data, 32'h4000_0003);
        chk("cary_rn", z(rn_wr_en), 32'h0);
        @(posedge clk);
        call_link_register <= 32'h0000_1230;
        flags_word_in <= 32'h4000_0000;
        send(OP_SUB_RET, 1'b0, 1'b0);
        chk("sr_blk", z(irq_block), 32'h1);
        chk("sr_tgt", branch_target, 32'h0000_1230);
        chk("sr_go0", z(branch_go), 32'h0);
        // The link was restored before the return, never in its slot
        @(posedge clk);
        target_value <= 32'h0000_0002;
        send(OP_ROT_RRC | 16'h0300, 1'b0, 1'b0);
        chk("sr_go", z(branch_go), 32'h1);
        chk("sr_hold", branch_target, 32'h0000_1230);
        chk("sr_slot", rn_wr_data, 32'h0000_0001);
        chk("sr_unblk", z(irq_block), 32'h0);
        @(posedge clk);
        saved_flags_word <= 32'h0000_0001;
        exception_return_address <= 32'h0000_8000;
        send(OP_EXC_RET, 1'b0, 1'b0);
        chk("er_fetch", slot_fetch_flags, 32'h4000_0000);
        chk("er_tgt", branch_target, 32'h0000_8000);
        for (int k = 1; k <= 3; k++) begin
            chk("er_rdy", z(issue_ready), 32'h0);
            chk("er_blk", z(irq_block), 32'h1);
            chk("er_fen", z(flags_wr_en), z(k == 3));
            if (k < 3) @(negedge clk);
        end
        chk("er_rest", flags_wr_data, 32'h0000_0001);
        // Restored word committed; the saved address moves under the slot
        @(posedge clk);
        flags_word_in <= 32'h0000_0001;
        target_value <= 32'h0000_0004;
        exception_return_address <= 32'h0000_9000;
        send(OP_ROT_RCR, 1'b0, 1'b0);
        chk("er_go", z(branch_go), 32'h1);
        chk("er_slot", rn_wr_data, 32'h8000_0002);
        chk("er_tgt2", branch_target, 32'h0000_8000);
        send(OP_EXC_RET, 1'b0, 1'b0);
        chk("usr_ill", z(illegal_general), 32'h1);
        chk("usr_blk", z(irq_block), 32'h0);
        @(posedge clk);
        flags_word_in <= 32'h4000_0000;
        send(OP_EXC_RET, 1'b1, 1'b0);
        chk("in_slot", z(illegal_slot), 32'h1);
        chk("in_slot_g", z(illegal_general), 32'h0);
        send(OP_SUB_RET, 1'b0, 1'b0);
        send(OP_SUB_RET, 1'b0, 1'b1);
        chk("br_slot", z(illegal_slot), 32'h1);
        chk("br_go", z(branch_go), 32'h0);
        rchk("stat_ev", ADDR_STATUS, 32'h7);
        chk("irq0", z(irq), 32'h0);
        apb(1'b1, ADDR_MASK, 32'h2);
        irq_chk("irq_on", 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h2);
        irq_chk("irq_off", 1'b0);
        rchk("stat_clr", ADDR_STATUS, 32'h5);
        apb(1'b1, ADDR_CTRL, 32'h0);
        irq_chk("irq_off2", 1'b0);
        chk("ctrl_off", z(issue_ready), 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        irq_chk("irq_off3", 1'b0);
        chk("ctrl_on", z(issue_ready), 32'h1);
        close_out();
    end
endmodule // tb

/* File: verilog/rotate_return_flag_exec.sv */
// Execution logic for single-bit rotates, delayed returns and flag sets.
// Assumes the core presents operands on the same clock and commits the
// write-back pulses at the following edge; registers sit behind APB.
//
// Summary of operation
// - Rotate through carry right: old carry into MSB, old LSB to carry.
// - Rotate left circular: old MSB into LSB and carry.
// - Rotate right circular: old LSB into MSB and carry.
// - Exception return loads flags and PC from saved copies, four cycles.
// - Exception return in user mode raises general illegal instruction.
// - Both returns are delayed: the next instruction runs first.
// - No interrupt is accepted between a return and its slot.
// - A branch in a return's delay slot is a slot illegal instruction.
// - Exception return inside another branch's slot is slot illegal.
// - Slot instruction sees the flag word just restored.
// - Slot fetch uses flags and privilege from before the return.
// - Branch target is captured before the slot instruction runs.
// - Return updates, then slot updates, then the transfer happens.
// - Subroutine return loads PC from call link register in one cycle.
// - Set-clamp forces saturation flag to one, carry untouched.
// - Set-carry forces carry to one, nothing else changes.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps

module rotate_return_flag_exec
    import rotate_return_flag_pkg::*;
#(
    parameter logic [15:0] EXC_RET_OP  = OP_EXC_RET,
    parameter logic [15:0] SET_CLMP_OP = OP_SET_CLMP,
    parameter logic [15:0] SET_CARY_OP = OP_SET_CARY
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Issue and operands
    input  wire issue_t      issue,
    input  wire logic [31:0] target_value,
    input  wire logic [31:0] flags_word_in,
    input  wire logic [31:0] saved_flags_word,
    input  wire logic [31:0] exception_return_address,
    input  wire logic [31:0] call_link_register,
    // Results
    output logic             issue_ready,
    output logic             rn_wr_en,
    output logic      [3:0]  rn_wr_idx,
    output logic      [31:0] rn_wr_data,
    output logic             flags_wr_en,
    output logic      [31:0] flags_wr_data,
    output logic      [31:0] slot_fetch_flags,
    output logic             branch_go,
    output logic      [31:0] branch_target,
    output logic             irq_block,
    output logic             illegal_general,
    output logic             illegal_slot,
    output logic             irq
);

    function automatic logic op_is(input logic [15:0] op,
                                   input logic [15:0] mask,
                                   input logic [15:0] code);
        op_is = (op & mask) == code;
    endfunction

    state_t        state_ff;
    state_t        nxt_state;
    logic [2:0]    cnt_ff;
    logic [2:0]    nxt_cnt;
    logic [31:0]   saved_ff;
    logic          ready_ff;
    logic          nxt_ready;
    logic          rn_en_ff;
    logic [3:0]    rn_idx_ff;
    logic [31:0]   rn_data_ff;
    logic          fl_en_ff;
    logic          nxt_fl_en;
    logic [31:0]   fl_data_ff;
    logic [31:0]   nxt_fl_data;
    logic [31:0]   fetch_fl_ff;
    logic          go_ff;
    logic [31:0]   target_ff;
    logic          block_ff;
    logic          gen_ill_ff;
    logic          slot_ill_ff;
    logic [31:0]   ctrl_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] nxt_status;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] ev;
    logic          irq_ff;
    logic [31:0]   prdata_ff;
    logic          pready_ff;
    logic          pslverr_ff;
    logic [31:0]   flags_mod;

    // Decode
    wire [15:0] op       = issue.op;
    wire acc            = issue.valid && ready_ff;
    wire hit_rcr        = op_is(op, OP_REG_MASK, OP_ROT_RCR);
    wire hit_rlc        = op_is(op, OP_REG_MASK, OP_ROT_RLC);
    wire hit_rrc        = op_is(op, OP_REG_MASK, OP_ROT_RRC);
    wire hit_sret       = op == OP_SUB_RET;
    wire hit_eret       = op == EXC_RET_OP;
    wire hit_sclamp     = op == SET_CLMP_OP;
    wire hit_scarry     = op == SET_CARY_OP;
    wire rot_hit        = hit_rcr | hit_rlc | hit_rrc;
    wire is_ret         = hit_eret | hit_sret;
    wire in_slot_phase  = state_ff == ST_SLOT;
    wire user_mode      = !flags_word_in[PRIV_BIT];
    wire old_c          = flags_word_in[CARRY_BIT];

    // Slot legality; slot illegal takes priority over privilege
    wire slot_ill       = (in_slot_phase && (issue.is_branch || is_ret))
                        || (is_ret && issue.in_slot);
    wire gen_ill        = hit_eret && !slot_ill && user_mode;
    wire start_eret     = acc && hit_eret && !slot_ill && !user_mode;
    wire start_sret     = acc && hit_sret && !slot_ill;
    wire slot_done      = acc && in_slot_phase;
    wire eret_restore   = state_ff == ST_ERET && cnt_ff == ERET_CYCLES - 3'h2;
    wire eret_to_slot   = state_ff == ST_ERET && cnt_ff == 3'h1;

    // Rotates
    wire [31:0] rot_val =
        hit_rcr ? {old_c, target_value[31:1]} :
        hit_rlc ? {target_value[30:0], target_value[31]} :
                  {target_value[0], target_value[31:1]};
    wire rot_c = hit_rlc ? target_value[31] : target_value[0];

    always_comb begin
        flags_mod = flags_word_in;
        flags_mod[CARRY_BIT] = rot_hit ? rot_c : (hit_scarry | old_c);
        flags_mod[CLAMP_BIT] = hit_sclamp | flags_word_in[CLAMP_BIT];
    end

    // Sequencer next values
    assign nxt_state = start_eret ? ST_ERET :
                       start_sret ? ST_SLOT :
                       eret_to_slot ? ST_SLOT :
                       slot_done ? ST_IDLE : state_ff;
    assign nxt_cnt   = start_eret ? ERET_CYCLES - 3'h1 :
                       (state_ff == ST_ERET) ? cnt_ff - 3'h1 : cnt_ff;
    // Acceptance stalls for the whole exception return; the slot is always taken
    assign nxt_ready = (nxt_state == ST_ERET) ? 1'b0 :
                       (nxt_state == ST_SLOT) ? 1'b1 :
                       ctrl_ff[CTRL_EN_BIT];
    assign nxt_fl_en   = (acc && (rot_hit | hit_sclamp | hit_scarry))
                       || eret_restore;
    assign nxt_fl_data = eret_restore ? saved_ff : flags_mod;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 3'h0;
            ready_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            ready_ff <= nxt_ready;
        end
    end

    // Write-back of register and flag word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rn_en_ff   <= 1'b0;
            rn_idx_ff  <= 4'h0;
            rn_data_ff <= 32'h0000_0000;
            fl_en_ff   <= 1'b0;
            fl_data_ff <= 32'h0000_0000;
        end else begin
            rn_en_ff   <= acc && rot_hit;
            rn_idx_ff  <= op[RN_MSB:RN_LSB];
            rn_data_ff <= rot_val;
            fl_en_ff   <= nxt_fl_en;
            fl_data_ff <= nxt_fl_data;
        end
    end

    // Return bookkeeping: target and flags are frozen at the return
    // itself so a slot write to the source cannot move the destination.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            saved_ff    <= 32'h0000_0000;
            target_ff   <= 32'h0000_0000;
            fetch_fl_ff <= 32'h0000_0000;
        end else if (start_eret) begin
            saved_ff    <= saved_flags_word;
            target_ff   <= exception_return_address;
            fetch_fl_ff <= flags_word_in;
        end else if (start_sret) begin
            target_ff   <= call_link_register;
            fetch_fl_ff <= flags_word_in;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            go_ff       <= 1'b0;
            block_ff    <= 1'b0;
            gen_ill_ff  <= 1'b0;
            slot_ill_ff <= 1'b0;
        end else begin
            go_ff       <= slot_done && !slot_ill;
            block_ff    <= (start_eret | start_sret)
                         || (block_ff && !slot_done);
            gen_ill_ff  <= acc && gen_ill;
            slot_ill_ff <= acc && slot_ill;
        end
    end

    // APB slave: one wait state, answer from flops
    wire apb_acc   = psel && penable;
    wire apb_done  = apb_acc && pready_ff;
    wire apb_wr    = apb_done && pwrite;
    wire sel_ctrl  = paddr == ADDR_CTRL;
    wire sel_stat  = paddr == ADDR_STATUS;
    wire sel_mask  = paddr == ADDR_MASK;
    wire sel_state = paddr == ADDR_STATE;
    wire mapped    = sel_ctrl | sel_stat | sel_mask | sel_state;
    wire [31:0] rd_mux =
        sel_ctrl ? ctrl_ff :
        sel_stat ? {{(32-EV_W){1'b0}}, status_ff} :
        sel_mask ? {{(32-EV_W){1'b0}}, mask_ff} :
        sel_state ? {27'h0, block_ff, cnt_ff[1:0], state_ff} : 32'h0;
    wire wr_stat = apb_wr && sel_stat;

    assign ev[EV_GEN]  = acc && gen_ill;
    assign ev[EV_SLOT] = acc && slot_ill;
    assign ev[EV_XFER] = slot_done && !slot_ill;

    // A new event wins over a write-one-to-clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_ev
            assign nxt_status[gi] = ev[gi]
                || (status_ff[gi] && !(wr_stat && pwdata[gi]));
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= apb_acc && !pready_ff;
            prdata_ff  <= (apb_acc && !pready_ff && !pwrite) ? rd_mux
                                                             : prdata_ff;
            pslverr_ff <= apb_acc && !pready_ff && !mapped;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_ff   <= CTRL_RESET;
            mask_ff   <= '0;
            status_ff <= '0;
            irq_ff    <= 1'b0;
        end else begin
            if (apb_wr && sel_ctrl)
                ctrl_ff <= pwdata;
            if (apb_wr && sel_mask)
                mask_ff <= pwdata[EV_W-1:0];
            status_ff <= nxt_status;
            irq_ff    <= |(nxt_status & mask_ff);
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign issue_ready      = ready_ff;
    assign rn_wr_en         = rn_en_ff;
    assign rn_wr_idx        = rn_idx_ff;
    assign rn_wr_data       = rn_data_ff;
    assign flags_wr_en      = fl_en_ff;
    assign flags_wr_data    = fl_data_ff;
    assign slot_fetch_flags = fetch_fl_ff;
    assign branch_go        = go_ff;
    assign branch_target    = target_ff;
    assign irq_block        = block_ff;
    assign illegal_general  = gen_ill_ff;
    assign illegal_slot     = slot_ill_ff;
    assign irq              = irq_ff;

    // Checks; operand copies give the prior-cycle operands
    logic [31:0] tv_q;
    logic [31:0] fw_q;
    always_ff @(posedge clk) begin
        tv_q <= target_value;
        fw_q <= flags_word_in;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_rcr;
        acc && hit_rcr |=> rn_wr_en && rn_wr_data ==
            {fw_q[CARRY_BIT], tv_q[31:1]}
            && flags_wr_data[CARRY_BIT] == tv_q[0];
    endproperty
    a_rcr: assert property (p_rcr)
        else $error("rotate via carry result wrong");

    property p_rlc;
        acc && hit_rlc |=> rn_wr_data == {tv_q[30:0], tv_q[31]}
            && flags_wr_data[CARRY_BIT] == tv_q[31];
    endproperty
    a_rlc: assert property (p_rlc)
        else $error("rotate left result wrong");

    property p_rrc;
        acc && hit_rrc |=> rn_wr_data == {tv_q[0], tv_q[31:1]}
            && flags_wr_data[CARRY_BIT] == tv_q[0];
    endproperty
    a_rrc: assert property (p_rrc)
        else $error("rotate right result wrong");

    property p_eret_len;
        start_eret |=> !issue_ready [*3] ##1 issue_ready;
    endproperty
    a_eret_len: assert property (p_eret_len)
        else $error("exception return not four cycles");

    property p_user;
        acc && hit_eret && !issue.in_slot && !in_slot_phase
            && user_mode |=> illegal_general && state_ff == ST_IDLE;
    endproperty
    a_user: assert property (p_user)
        else $error("user mode return not refused");

    property p_block;
        state_ff != ST_IDLE |-> irq_block;
    endproperty
    a_block: assert property (p_block)
        else $error("interrupts open inside return");

    property p_slot_br;
        acc && in_slot_phase && issue.is_branch
            |=> illegal_slot && !branch_go;
    endproperty
    a_slot_br: assert property (p_slot_br)
        else $error("branch in slot not refused");

    property p_eret_in_slot;
        acc && hit_eret && issue.in_slot |=> illegal_slot && !irq_block;
    endproperty
    a_eret_in_slot: assert property (p_eret_in_slot)
        else $error("return in slot not refused");

    property p_restore;
        start_eret |-> ##3 flags_wr_en
            && flags_wr_data == $past(saved_flags_word, 3);
    endproperty
    a_restore: assert property (p_restore)
        else $error("flag word not restored before slot");

    property p_fetch;
        start_eret |=> slot_fetch_flags == $past(flags_word_in);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("slot fetch flags not the old ones");

    property p_sret;
        start_sret |=> branch_target == $past(call_link_register)
            && issue_ready;
    endproperty
    a_sret: assert property (p_sret)
        else $error("subroutine return target wrong");

    property p_go;
        slot_done && !slot_ill |=> branch_go && !irq_block;
    endproperty
    a_go: assert property (p_go)
        else $error("transfer missing after slot");

    property p_clamp;
        acc && hit_sclamp |=> flags_wr_en && flags_wr_data[CLAMP_BIT]
            && flags_wr_data[CARRY_BIT] == fw_q[CARRY_BIT];
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("set clamp wrong");

    property p_carry;
        acc && hit_scarry |=> flags_wr_en && flags_wr_data[CARRY_BIT]
            && !rn_wr_en;
    endproperty
    a_carry: assert property (p_carry)
        else $error("set carry wrong");

    c_eret: cover property (start_eret ##5 branch_go);
    c_sret: cover property (start_sret ##2 branch_go);
    c_slot: cover property (illegal_slot && !branch_go);

endmodule // rotate_return_flag_exec

/* File: verilog/rotate_return_flag_pkg.sv */
// Constants and types for the rotate, return and flag-set execution block.
// Assumes a 16-bit opcode issue stream and a 32-bit APB register port.
package rotate_return_flag_pkg;

    // Opcode matching
    localparam logic [15:0] OP_REG_MASK = 16'hF0FF;
    localparam logic [15:0] OP_ROT_RCR  = 16'h4025;
    localparam logic [15:0] OP_ROT_RLC  = 16'h4004;
    localparam logic [15:0] OP_ROT_RRC  = 16'h4005;
    localparam logic [15:0] OP_SUB_RET  = 16'h000B;
    localparam logic [15:0] OP_EXC_RET  = 16'h002B;
    localparam logic [15:0] OP_SET_CLMP = 16'h0058;
    localparam logic [15:0] OP_SET_CARY = 16'h0018;
    localparam int          RN_LSB      = 8;
    localparam int          RN_MSB      = 11;

    // Flag word bit positions
    localparam int CARRY_BIT = 0;
    localparam int CLAMP_BIT = 1;
    localparam int PRIV_BIT  = 30;

    // Exception return occupancy in clock cycles
    localparam logic [2:0] ERET_CYCLES = 3'h4;

    // Register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_MASK   = 8'h08;
    localparam logic [7:0]  ADDR_STATE  = 8'h0C;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam int          CTRL_EN_BIT = 0;

    // Event bits in status and mask
    localparam int EV_W    = 3;
    localparam int EV_GEN  = 0;
    localparam int EV_SLOT = 1;
    localparam int EV_XFER = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ERET = 2'b01,
        ST_SLOT = 2'b10
    } state_t;

    typedef struct packed {
        logic        valid;
        logic        in_slot;
        logic        is_branch;
        logic [15:0] op;
    } issue_t;

endpackage
